// file: src/ict_defines.svh
// timing constants for the instruction cycle timing sequencer
`ifndef ICT_DEFINES_SVH
`define ICT_DEFINES_SVH
`define ICT_CLK_W 12
`define ICT_CNT_W 10
`define ICT_SYS_CLK_HZ 20000000
`define ICT_BUS_CLKS 4
`define ICT_SHIFT_BASE 10
`define ICT_SHIFT_LONG_BASE 12
`define ICT_SHIFT_RD 2
`define ICT_SHIFT_MEM_CLKS 16
`define ICT_SHIFT_MEM_RD 2
`define ICT_SHIFT_MEM_WR 2
`define ICT_JUMP_CLKS 16
`define ICT_JUMP_RD 4
`define ICT_CALL_CLKS 32
`define ICT_CALL_RD 4
`define ICT_CALL_WR 4
`define ICT_LOAD_ADDR_CLKS 8
`define ICT_LOAD_ADDR_RD 2
`define ICT_PUSH_ADDR_CLKS 24
`define ICT_PUSH_ADDR_RD 2
`define ICT_PUSH_ADDR_WR 4
`define ICT_MULTI_REGISTER_MOVE_M2R_BASE 24
`define ICT_MULTI_REGISTER_MOVE_M2R_RD 6
`define ICT_MULTI_REGISTER_MOVE_R2M_BASE 16
`define ICT_MULTI_REGISTER_MOVE_R2M_RD 4
`define ICT_MULTI_REGISTER_MOVE_WORD_CLKS 8
`define ICT_MULTI_REGISTER_MOVE_LONG_CLKS 16
`define ICT_ARITH_BW_CLKS 4
`define ICT_ARITH_LONG_CLKS 6
`define ICT_ARITH_LONG_REG_CLKS 8
`define ICT_ARITH_MEM_BW_CLKS 8
`define ICT_ARITH_MEM_LONG_CLKS 12
`define ICT_XOR_LONG_CLKS 8
`define ICT_MUL_BASE 38
`define ICT_MUL_MAX 70
`define ICT_SIGNED_DIVIDE_CLKS 158
`define ICT_UNSIGNED_DIVIDE_CLKS 140
`define ICT_INT_CLKS 44
`define ICT_INT_RD 5
`define ICT_INT_WR 3
`define ICT_RESET_CLKS 40
`define ICT_RESET_RD 6
`endif

// file: src/ict_pkg.sv
// types shared by the instruction cycle timing sequencer
package ict_pkg;
  typedef enum logic [3:0] {
    ICT_OP_SHIFT,
    ICT_OP_JUMP,
    ICT_OP_CALL,
    ICT_OP_LOAD_ADDR,
    ICT_OP_PUSH_ADDR,
    ICT_OP_MOVE_MULTI,
    ICT_OP_ARITH,
    ICT_OP_XOR,
    ICT_OP_MULTIPLY,
    ICT_OP_DIVIDE,
    ICT_OP_INTERRUPT
  } ict_op_t;

  typedef enum logic [1:0] {
    ICT_SZ_BYTE,
    ICT_SZ_WORD,
    ICT_SZ_LONG
  } ict_size_t;

  typedef struct packed {
    logic [11:0] clks;
    logic [9:0] rd;
    logic [9:0] wr;
  } ict_cost_t;
endpackage : ict_pkg

// file: src/ict_mul_count.sv
// variable count for the multiply timing: ones or bit transitions
`timescale 1ns/1ps
module ict_mul_count (
  input wire logic [15:0] operand_i,
  input wire logic signed_i,
  output logic [4:0] count_o
);
  logic [16:0] ext;
  logic [15:0] pat;

  // signed form looks at neighbour pairs of the source with a zero appended below
  always_comb
  begin
    ext = {operand_i, 1'b0};
    pat = signed_i ? (ext[16:1] ^ ext[15:0]) : operand_i;
    count_o = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      count_o = count_o + {4'h0, pat[i]};
    end
  end
endmodule : ict_mul_count

// file: src/ict_timing.sv
// instruction cycle timing sequencer: table cost and bus-paced execution
`timescale 1ns/1ps
`include "ict_defines.svh"
// How it works
// [RL1] every entry yields clocks, reads and writes, and flagged entries add the address-calculation triple.
// [RL2] register shifts and rotates of byte or word cost ten plus two per position with two reads.
// [RL3] a memory shift is word only and costs sixteen clocks, two reads, two writes plus address time.
// [RL4] multi-register moves grow by eight or sixteen clocks and two or four bus cycles per register.
// [RL5] the width of an index register never changes the time taken.
// [RL6] two-operand figures include both fetches, the operation, the store and the next fetch.
// [RL7] long add, subtract, and, or into a register take six clocks, or eight from a register or immediate.
// [RL8] exclusive-or into a data register takes four or eight clocks with one read.
// [RL9] signed divide takes 158 clocks, unsigned 140, and best and worst differ by under ten percent.
// [RL10] multiply takes thirty-eight plus two per counted feature, at most seventy, one read.
// [RL11] unsigned multiply counts the one bits of the source.
// [RL12] signed multiply counts the 01 or 10 pairs of the source with a zero appended below.
// [RL13] interrupt entry takes forty-four clocks, five reads and three writes.
// [RL14] reset entry takes forty clocks and six reads once reset and halt are seen released.
// [RL15] each bus cycle takes a fixed four clocks, and wait states stretch the measured total.
// [RL16] the cost is the table entry summed with the address-calculation cost where flagged.
module ict_timing (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic halt_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire ict_pkg::ict_op_t op_i,
  input wire ict_pkg::ict_size_t size_i,
  input wire logic mem_dst_i,
  input wire logic src_reg_i,
  input wire logic signed_i,
  input wire logic [5:0] count_i,
  input wire logic [15:0] operand_i,
  input wire logic [5:0] ea_clks_i,
  input wire logic [2:0] ea_reads_i,
  input wire logic [2:0] ea_writes_i,
  output logic bus_req_o,
  output logic bus_write_o,
  input wire logic bus_ready_i,
  output logic done_o,
  output logic reset_done_o,
  output logic [11:0] clocks_o,
  output logic [9:0] reads_o,
  output logic [9:0] writes_o
);
  typedef enum {ST_RESET_WAIT, ST_IDLE, ST_RUN, ST_BUS, ST_DONE} ict_state_t;

  ict_state_t state_reg, state_next;
  ict_pkg::ict_cost_t cost_reg, cost_next, req_cost;
  logic [11:0] int_left_reg, int_left_next, elapsed_reg, elapsed_next, waits_reg, waits_next;
  logic [9:0] rd_left_reg, rd_left_next, wr_left_reg, wr_left_next;
  logic [1:0] phase_reg, phase_next;
  logic rst_seq_reg, rst_seq_next, done_reg, done_next;
  logic [2:0] halt_sync_reg, halt_sync_next, rdy_sync_reg, rdy_sync_next;
  logic halt_filt_reg, halt_filt_next, rdy_filt_reg, rdy_filt_next;
  logic [4:0] mul_n;

  ict_mul_count u_mul_count (
    .operand_i(operand_i),
    .signed_i(signed_i),
    .count_o(mul_n)
  );

  // table lookup for one request; flagged entries take the address cost
  function automatic ict_pkg::ict_cost_t op_cost(input ict_pkg::ict_op_t op, input ict_pkg::ict_size_t sz,
      input logic mem, input logic src_reg, input logic sgn, input logic [5:0] n, input logic [4:0] mn,
      input logic [5:0] ea_c, input logic [2:0] ea_r, input logic [2:0] ea_w);
    ict_pkg::ict_cost_t c;
    logic plus;
    logic lng;
    logic [11:0] n12;
    logic [9:0] n10;
    c = '0;
    plus = 1'b0;
    lng = (sz == ict_pkg::ICT_SZ_LONG);
    n12 = {6'h00, n};
    n10 = {4'h0, n};
    case (op)
      ict_pkg::ICT_OP_SHIFT:
      begin
        if (mem)
        begin
          c = '{12'(`ICT_SHIFT_MEM_CLKS), 10'(`ICT_SHIFT_MEM_RD), 10'(`ICT_SHIFT_MEM_WR)}; // [RL3]
          plus = 1'b1;
        end
        else
        begin
          c.clks = 12'(lng ? `ICT_SHIFT_LONG_BASE : `ICT_SHIFT_BASE) + (n12 << 1); // [RL2]
          c.rd = 10'(`ICT_SHIFT_RD);
        end
      end
      ict_pkg::ICT_OP_JUMP: c = '{12'(`ICT_JUMP_CLKS), 10'(`ICT_JUMP_RD), 10'h000};
      ict_pkg::ICT_OP_CALL: c = '{12'(`ICT_CALL_CLKS), 10'(`ICT_CALL_RD), 10'(`ICT_CALL_WR)};
      ict_pkg::ICT_OP_LOAD_ADDR: c = '{12'(`ICT_LOAD_ADDR_CLKS), 10'(`ICT_LOAD_ADDR_RD), 10'h000};
      ict_pkg::ICT_OP_PUSH_ADDR: c = '{12'(`ICT_PUSH_ADDR_CLKS), 10'(`ICT_PUSH_ADDR_RD), 10'(`ICT_PUSH_ADDR_WR)};
      ict_pkg::ICT_OP_MOVE_MULTI:
      begin
        // mem set means registers to memory
        c.clks = 12'(mem ? `ICT_MULTI_REGISTER_MOVE_R2M_BASE : `ICT_MULTI_REGISTER_MOVE_M2R_BASE)
               + (n12 << (lng ? 4 : 3)); // [RL4]
        if (mem)
        begin
          c.rd = 10'(`ICT_MULTI_REGISTER_MOVE_R2M_RD);
          c.wr = n10 << (lng ? 2 : 1);
        end
        else
          c.rd = 10'(`ICT_MULTI_REGISTER_MOVE_M2R_RD) + (n10 << (lng ? 2 : 1));
      end
      ict_pkg::ICT_OP_ARITH, ict_pkg::ICT_OP_XOR:
      begin
        // figures already hold operand fetch, store and next fetch [RL6]
        c.rd = 10'h001;
        plus = 1'b1;
        if (mem)
        begin
          c.clks = 12'(lng ? `ICT_ARITH_MEM_LONG_CLKS : `ICT_ARITH_MEM_BW_CLKS);
          c.wr = lng ? 10'h002 : 10'h001;
        end
        else if (op == ict_pkg::ICT_OP_XOR)
        begin
          c.clks = 12'(lng ? `ICT_XOR_LONG_CLKS : `ICT_ARITH_BW_CLKS); // [RL8]
          plus = 1'b0;
        end
        else if (lng)
          c.clks = 12'(src_reg ? `ICT_ARITH_LONG_REG_CLKS : `ICT_ARITH_LONG_CLKS); // [RL7]
        else
          c.clks = 12'(`ICT_ARITH_BW_CLKS);
      end
      ict_pkg::ICT_OP_MULTIPLY:
      begin
        c.clks = 12'(`ICT_MUL_BASE) + {6'h00, mn, 1'b0}; // [RL10] [RL11] [RL12]
        c.rd = 10'h001;
        plus = 1'b1;
      end
      ict_pkg::ICT_OP_DIVIDE:
      begin
        // fixed worst case, so best and worst are equal [RL9]
        c.clks = 12'(sgn ? `ICT_SIGNED_DIVIDE_CLKS : `ICT_UNSIGNED_DIVIDE_CLKS);
        c.rd = 10'h001;
        plus = 1'b1;
      end
      ict_pkg::ICT_OP_INTERRUPT: c = '{12'(`ICT_INT_CLKS), 10'(`ICT_INT_RD), 10'(`ICT_INT_WR)}; // [RL13]
      default: c = '0;
    endcase
    // address cost has no index-width term at all [RL5]
    if (plus)
    begin
      c.clks = c.clks + {6'h00, ea_c}; // [RL1] [RL16]
      c.rd = c.rd + {7'h00, ea_r};
      c.wr = c.wr + {7'h00, ea_w};
    end
    return c;
  endfunction : op_cost

  // pin inputs pass three flops; a change counts once stages two and three agree
  always_comb
  begin
    halt_sync_next = {halt_sync_reg[1:0], halt_n_i};
    rdy_sync_next = {rdy_sync_reg[1:0], bus_ready_i};
    halt_filt_next = (halt_sync_reg[1] == halt_sync_reg[2]) ? halt_sync_reg[2] : halt_filt_reg;
    rdy_filt_next = (rdy_sync_reg[1] == rdy_sync_reg[2]) ? rdy_sync_reg[2] : rdy_filt_reg;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      halt_sync_reg <= 3'h0;
      rdy_sync_reg <= 3'h0;
      halt_filt_reg <= 1'b0;
      rdy_filt_reg <= 1'b0;
    end
    else
    begin
      halt_sync_reg <= halt_sync_next;
      rdy_sync_reg <= rdy_sync_next;
      halt_filt_reg <= halt_filt_next;
      rdy_filt_reg <= rdy_filt_next;
    end
  end

  assign req_cost = op_cost(op_i, size_i, mem_dst_i, src_reg_i, signed_i, count_i, mul_n,
                            ea_clks_i, ea_reads_i, ea_writes_i);
  assign req_ready_o = (state_reg == ST_IDLE);
  assign bus_req_o = (state_reg == ST_BUS);
  assign bus_write_o = (state_reg == ST_BUS) && (rd_left_reg == 10'h000);
  assign done_o = done_reg;
  assign reset_done_o = done_reg && rst_seq_reg;
  assign clocks_o = elapsed_reg;
  assign reads_o = cost_reg.rd;
  assign writes_o = cost_reg.wr;

  // sequencer: internal clocks first, then reads, then writes
  always_comb
  begin
    ict_pkg::ict_cost_t ld;
    logic load;
    logic [11:0] bus_clks;
    ld = req_cost;
    load = 1'b0;
    bus_clks = 12'h000;
    state_next = state_reg;
    cost_next = cost_reg;
    int_left_next = int_left_reg;
    rd_left_next = rd_left_reg;
    wr_left_next = wr_left_reg;
    phase_next = phase_reg;
    elapsed_next = elapsed_reg;
    waits_next = waits_reg;
    rst_seq_next = rst_seq_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_RESET_WAIT:
      begin
        if (halt_filt_reg)
        begin
          ld = '{12'(`ICT_RESET_CLKS), 10'(`ICT_RESET_RD), 10'h000}; // [RL14]
          load = 1'b1;
          rst_seq_next = 1'b1;
        end
      end
      ST_IDLE:
      begin
        if (req_valid_i)
        begin
          load = 1'b1;
          rst_seq_next = 1'b0;
        end
      end
      ST_RUN:
      begin
        elapsed_next = elapsed_reg + 12'h001;
        int_left_next = int_left_reg - 12'h001;
        if (int_left_reg == 12'h001)
          state_next = ((rd_left_reg | wr_left_reg) != 10'h000) ? ST_BUS : ST_DONE;
      end
      ST_BUS:
      begin
        // fixed four clocks per access, extended while the bus is not ready [RL15]
        elapsed_next = elapsed_reg + 12'h001;
        if (phase_reg != 2'(`ICT_BUS_CLKS - 1))
          phase_next = phase_reg + 2'h1;
        else if (!rdy_filt_reg)
          waits_next = waits_reg + 12'h001;
        else
        begin
          phase_next = 2'h0;
          if (rd_left_reg != 10'h000)
            rd_left_next = rd_left_reg - 10'h001;
          else
            wr_left_next = wr_left_reg - 10'h001;
          if ((rd_left_reg + wr_left_reg) == 10'h001)
            state_next = ST_DONE;
        end
      end
      ST_DONE:
      begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (load)
    begin
      bus_clks = 12'(`ICT_BUS_CLKS) * {2'h0, ld.rd + ld.wr};
      cost_next = ld;
      int_left_next = ld.clks - bus_clks;
      rd_left_next = ld.rd;
      wr_left_next = ld.wr;
      phase_next = 2'h0;
      elapsed_next = 12'h000;
      waits_next = 12'h000;
      state_next = (ld.clks != bus_clks) ? ST_RUN : ST_BUS;
    end
    if (state_next == ST_DONE)
      done_next = 1'b1;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_reg <= ST_RESET_WAIT;
      cost_reg <= '0;
      int_left_reg <= 12'h000;
      rd_left_reg <= 10'h000;
      wr_left_reg <= 10'h000;
      phase_reg <= 2'h0;
      elapsed_reg <= 12'h000;
      waits_reg <= 12'h000;
      rst_seq_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cost_reg <= cost_next;
      int_left_reg <= int_left_next;
      rd_left_reg <= rd_left_next;
      wr_left_reg <= wr_left_next;
      phase_reg <= phase_next;
      elapsed_reg <= elapsed_next;
      waits_reg <= waits_next;
      rst_seq_reg <= rst_seq_next;
      done_reg <= done_next;
    end
  end

  logic acc;
  assign acc = req_valid_i && req_ready_o;

  property p_total;
    @(posedge sys_clk_i) disable iff (!nrst_i) done_o |-> clocks_o == cost_reg.clks + waits_reg;
  endproperty
  a_total: assert property (p_total) else $error("elapsed clocks differ from cost plus waits"); // [RL15]

  property p_shift_reg;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      acc && op_i == ict_pkg::ICT_OP_SHIFT && !mem_dst_i && size_i != ict_pkg::ICT_SZ_LONG
      |=> cost_reg.clks == 12'(10 + 2 * $past(count_i)) && cost_reg.rd == 10'h002 && cost_reg.wr == 10'h000;
  endproperty
  a_shift_reg: assert property (p_shift_reg) else $error("register shift cost wrong"); // [RL2]

  property p_shift_mem;
    @(posedge sys_clk_i) disable iff (!nrst_i) acc && op_i == ict_pkg::ICT_OP_SHIFT && mem_dst_i
      |=> cost_reg.clks == 12'(16 + $past(ea_clks_i)) && cost_reg.wr == 10'(2 + $past(ea_writes_i));
  endproperty
  a_shift_mem: assert property (p_shift_mem) else $error("memory shift cost wrong"); // [RL3]

  property p_multi_register_move;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      acc && op_i == ict_pkg::ICT_OP_MOVE_MULTI && !mem_dst_i && size_i == ict_pkg::ICT_SZ_LONG
      |=> cost_reg.clks == 12'(24 + 16 * $past(count_i)) && cost_reg.rd == 10'(6 + 4 * $past(count_i));
  endproperty
  a_multi_register_move: assert property (p_multi_register_move) else $error("multi-register move cost wrong"); // [RL4]

  property p_arith_long;
    @(posedge sys_clk_i) disable iff (!nrst_i)
      acc && op_i == ict_pkg::ICT_OP_ARITH && !mem_dst_i && size_i == ict_pkg::ICT_SZ_LONG
      |=> cost_reg.clks == 12'(($past(src_reg_i) ? 8 : 6) + $past(ea_clks_i));
  endproperty
  a_arith_long: assert property (p_arith_long) else $error("long arithmetic cost wrong"); // [RL7]

  property p_xor;
    @(posedge sys_clk_i) disable iff (!nrst_i) acc && op_i == ict_pkg::ICT_OP_XOR && !mem_dst_i
      |=> cost_reg.rd == 10'h001 && cost_reg.clks == (($past(size_i) == ict_pkg::ICT_SZ_LONG) ? 12'h008 : 12'h004);
  endproperty
  a_xor: assert property (p_xor) else $error("exclusive-or cost wrong"); // [RL8]

  property p_div;
    @(posedge sys_clk_i) disable iff (!nrst_i) acc && op_i == ict_pkg::ICT_OP_DIVIDE
      |=> cost_reg.clks == 12'(($past(signed_i) ? 158 : 140) + $past(ea_clks_i));
  endproperty
  a_div: assert property (p_div) else $error("divide cost wrong"); // [RL9]

  property p_mul;
    @(posedge sys_clk_i) disable iff (!nrst_i) acc && op_i == ict_pkg::ICT_OP_MULTIPLY
      |=> cost_reg.clks <= 12'(70 + $past(ea_clks_i)) && cost_reg.clks == 12'(38 + 2 * $past(mul_n) + $past(ea_clks_i));
  endproperty
  a_mul: assert property (p_mul) else $error("multiply cost wrong"); // [RL10]

  property p_int;
    @(posedge sys_clk_i) disable iff (!nrst_i) acc && op_i == ict_pkg::ICT_OP_INTERRUPT
      |=> cost_reg.clks == 12'h02c && cost_reg.rd == 10'h005 && cost_reg.wr == 10'h003;
  endproperty
  a_int: assert property (p_int) else $error("interrupt entry cost wrong"); // [RL13]

  property p_reset;
    @(posedge sys_clk_i) disable iff (!nrst_i) reset_done_o |-> reads_o == 10'h006 && clocks_o >= 12'h028;
  endproperty
  a_reset: assert property (p_reset) else $error("reset entry cost wrong"); // [RL14]
endmodule : ict_timing

// file: bench/ict_bus_model.sv
// bus partner model: memory and peripherals answering prompt or with stalls
`timescale 1ns/1ps
module ict_bus_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic bus_req_i,
  input wire logic slow_i,
  input wire logic [3:0] stall_i,
  output logic bus_ready_o
);
  logic [3:0] cnt_reg;

  // slow: ready low for stall_i clocks then high for five, repeating while the bus request stays high
  // prompt: ready held high, so the sequencer sees zero wait states
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= 4'h0;
      bus_ready_o <= 1'b1;
    end
    else if (!slow_i || !bus_req_i)
    begin
      cnt_reg <= 4'h0;
      bus_ready_o <= !slow_i; // idle slow device never answers early
    end
    else
    begin
      cnt_reg <= (cnt_reg == stall_i + 4'h4) ? 4'h0 : cnt_reg + 4'h1;
      bus_ready_o <= (cnt_reg >= stall_i);
    end
  end
endmodule : ict_bus_model

// file: bench/instruction_cycle_timing_bench.sv
// self-checking bench for the instruction cycle timing sequencer
`timescale 1ns/1ps
module instruction_cycle_timing_bench;
  typedef struct {
    ict_pkg::ict_cost_t cost;
    logic rst;
    logic timed;
    int acc;
  } ict_exp_t;

  logic sys_clk_i, nrst_i, halt_n_i, req_valid_i, req_ready_o, mem_dst_i, src_reg_i, signed_i;
  ict_pkg::ict_op_t op_i;
  ict_pkg::ict_size_t size_i;
  logic [5:0] count_i, ea_clks_i;
  logic [15:0] operand_i;
  logic [2:0] ea_reads_i, ea_writes_i;
  logic bus_req_o, bus_write_o, bus_ready_i, done_o, reset_done_o, slow_mode;
  logic [11:0] clocks_o;
  logic [9:0] reads_o, writes_o;
  logic [3:0] stall;
  int cyc = 0;
  int n_fail, comparisons;
  int n_bus, n_wr;
  ict_exp_t exp_q[$];
  ict_exp_t got;

  ict_timing i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .halt_n_i(halt_n_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .op_i(op_i), .size_i(size_i), .mem_dst_i(mem_dst_i), .src_reg_i(src_reg_i),
    .signed_i(signed_i), .count_i(count_i), .operand_i(operand_i), .ea_clks_i(ea_clks_i),
    .ea_reads_i(ea_reads_i), .ea_writes_i(ea_writes_i), .bus_req_o(bus_req_o), .bus_write_o(bus_write_o),
    .bus_ready_i(bus_ready_i), .done_o(done_o), .reset_done_o(reset_done_o), .clocks_o(clocks_o),
    .reads_o(reads_o), .writes_o(writes_o));

  ict_bus_model i_bus (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req_o), .slow_i(slow_mode),
    .stall_i(stall), .bus_ready_o(bus_ready_i));

  // 20 MHz clock and a cycle count for latency measurement
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
    cyc <= cyc + 1;

  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic fail_out();
    n_fail++;
    end_of_test();
  endtask : fail_out

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  function automatic ict_pkg::ict_cost_t mk(input int c, input int r, input int w);
    ict_pkg::ict_cost_t v;
    v.clks = 12'(c);
    v.rd = 10'(r);
    v.wr = 10'(w);
    return v;
  endfunction : mk

  // expected table cost, worked out independently of the design
  function automatic ict_pkg::ict_cost_t cost_of(input int op, input int sz, input logic mem, input logic srcr,
      input logic sgn, input int n, input logic [15:0] opd, input int ec, input int er, input int ew);
    logic [16:0] x;
    int k;
    logic lng;
    lng = (sz == 2);
    x = {opd, 1'b0};
    k = 0;
    for (int b = 0; b < 16; b++)
      k += sgn ? int'(x[b+1] != x[b]) : int'(opd[b]);
    case (op)
      0: return mem ? mk(16 + ec, 2 + er, 2 + ew) : mk((lng ? 12 : 10) + 2 * n, 2, 0);
      1: return mk(16, 4, 0);
      2: return mk(32, 4, 4);
      3: return mk(8, 2, 0);
      4: return mk(24, 2, 4);
      5: return mem ? mk(16 + (lng ? 16 : 8) * n, 4, (lng ? 4 : 2) * n) : mk(24 + (lng ? 16 : 8) * n,
        6 + (lng ? 4 : 2) * n, 0);
      6: return mem ? mk((lng ? 12 : 8) + ec, 1 + er, (lng ? 2 : 1) + ew) : mk((lng ? (srcr ? 8 : 6) : 4) + ec,
        1 + er, ew);
      7: return mem ? mk((lng ? 12 : 8) + ec, 1 + er, (lng ? 2 : 1) + ew) : mk(lng ? 8 : 4, 1, 0);
      8: return mk(38 + 2 * k + ec, 1 + er, ew);
      9: return mk((sgn ? 158 : 140) + ec, 1 + er, ew);
      default: return mk(44, 5, 3);
    endcase
  endfunction : cost_of

  // drives one request with random address cost, notes the expectation on the falling edge before the taking edge
  task automatic issue(input int op, input int sz, input logic mem, input logic srcr, input logic sgn,
      input int n, input logic [15:0] opd);
    ict_exp_t e;
    int i;
    @(negedge sys_clk_i);
    op_i = ict_pkg::ict_op_t'(op);
    size_i = ict_pkg::ict_size_t'(sz);
    mem_dst_i = mem;
    src_reg_i = srcr;
    signed_i = sgn;
    count_i = 6'(n);
    operand_i = opd;
    ea_reads_i = 3'($urandom_range(2));
    ea_writes_i = 3'($urandom_range(1));
    ea_clks_i = 6'(4 * (ea_reads_i + ea_writes_i) + 2 * $urandom_range(3));
    req_valid_i = 1'b1;
    e.cost = cost_of(op, sz, mem, srcr, sgn, n, opd, ea_clks_i, ea_reads_i, ea_writes_i);
    e.rst = 1'b0;
    e.timed = 1'b1;
    for (i = 0; i < 3000 && req_ready_o !== 1'b1; i++)
      @(negedge sys_clk_i);
    if (i == 3000)
      fail_out();
    e.acc = cyc;
    exp_q.push_back(e);
    @(posedge sys_clk_i);
  endtask : issue

  task automatic drain();
    int i;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    for (i = 0; i < 3000 && exp_q.size() != 0; i++)
      @(negedge sys_clk_i);
    if (i == 3000)
      fail_out();
  endtask : drain

  task automatic reset_note();
    ict_exp_t r;
    r.cost = mk(40, 6, 0);
    r.rst = 1'b1;
    r.timed = 1'b0;
    r.acc = 0;
    exp_q.push_back(r);
  endtask : reset_note

  // result watcher: each done pulse takes the oldest note; bus request clocks counted per run
  always @(negedge sys_clk_i)
  begin
    if (nrst_i !== 1'b1)
    begin
      n_bus = 0;
      n_wr = 0;
    end
    else if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(done_o, 1'b0);
      else
      begin
        got = exp_q.pop_front();
        check(reads_o, got.cost.rd);
        check(writes_o, got.cost.wr);
        check(reset_done_o, got.rst);
        if (got.timed)
          check(clocks_o, cyc - got.acc - 1);
        if (slow_mode)
          check(clocks_o > got.cost.clks, 1'b1);
        else
        begin
          check(clocks_o, got.cost.clks);
          // zero waits: four bus clocks per access, writes only after reads
          check(n_bus, 4 * (got.cost.rd + got.cost.wr));
          check(n_wr, 4 * got.cost.wr);
        end
      end
      n_bus = 0;
      n_wr = 0;
    end
    else if (bus_req_o === 1'b1)
    begin
      n_bus++;
      if (bus_write_o === 1'b1)
        n_wr++;
    end
  end

  // main sequence
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    void'($urandom(32'h61b6));
    {nrst_i, halt_n_i, req_valid_i, mem_dst_i, src_reg_i, signed_i, slow_mode} = 7'h00;
    op_i = ict_pkg::ICT_OP_JUMP;
    size_i = ict_pkg::ICT_SZ_BYTE;
    {count_i, ea_clks_i, operand_i, ea_reads_i, ea_writes_i} = 34'h0;
    stall = 4'h2;
    repeat (2) @(negedge sys_clk_i);
    check({req_ready_o, bus_req_o, done_o}, 3'h0);
    reset_note();
    nrst_i = 1'b1;
    // halt still asserted: reset entry must wait
    repeat (8) @(negedge sys_clk_i);
    check(exp_q.size(), 1);
    halt_n_i = 1'b1;
    drain();
    // register shifts at count 0, 31, 62 and a memory shift, back to back
    for (int s = 0; s < 3; s++)
      issue(0, s, 1'b0, 1'b0, 1'b0, s * 31, 16'h0000);
    issue(0, 1, 1'b1, 1'b0, 1'b0, 5, 16'h0000);
    for (int o = 1; o < 5; o++)
      issue(o, 2, 1'b0, 1'b0, 1'b0, 0, 16'h0000);
    for (int s = 1; s < 3; s++)
      for (int m = 0; m < 2; m++)
        issue(5, s, m[0], 1'b0, 1'b0, m ? 16 : s, 16'h0000);
    for (int s = 0; s < 3; s++)
      for (int m = 0; m < 4; m++)
        issue(6, s, m[1], m[0], 1'b0, 0, 16'h0000);
    for (int s = 0; s < 3; s++)
      for (int m = 0; m < 2; m++)
        issue(7, s, m[0], 1'b0, 1'b0, 0, 16'h0000);
    for (int m = 0; m < 10; m++)
      issue(8, 1, 1'b0, 1'b0, m[0], 0, m < 8 ? 16'h5555 << (m / 2) : 16'($urandom()));
    issue(9, 1, 1'b0, 1'b0, 1'b1, 0, 16'h0000);
    issue(10, 2, 1'b0, 1'b0, 1'b0, 0, 16'h0000);
    // request held while busy must be ignored, not queued
    issue(9, 1, 1'b0, 1'b0, 1'b0, 0, 16'h0000);
    @(negedge sys_clk_i);
    op_i = ict_pkg::ICT_OP_INTERRUPT;
    repeat (3) @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    drain();
    // slow bus: wait states stretch the measured total
    slow_mode = 1'b1;
    stall = 4'(2 + $urandom_range(6));
    for (int o = 1; o < 11; o += 3)
      issue(o, 2, 1'b0, 1'b0, 1'b0, 0, 16'h0000);
    drain();
    slow_mode = 1'b0;
    // reset in mid-run abandons the operation and reruns reset entry
    issue(9, 1, 1'b0, 1'b0, 1'b1, 0, 16'h0000);
    repeat (10) @(negedge sys_clk_i);
    nrst_i = 1'b0;
    req_valid_i = 1'b0;
    exp_q.delete();
    repeat (2) @(negedge sys_clk_i);
    check({req_ready_o, bus_req_o, done_o, clocks_o}, 15'h0);
    reset_note();
    nrst_i = 1'b1;
    drain();
    end_of_test();
  end
endmodule : instruction_cycle_timing_bench
